// file: ufm_pkg.sv
package ufm_pkg;
	localparam logic [7:0] ADDR_DATA = 8'h00;
	localparam logic [7:0] ADDR_DIV_HIGH = 8'h04;
	localparam logic [7:0] ADDR_IMASK = 8'h08;
	localparam logic [7:0] ADDR_LFMT = 8'h0C;
	localparam logic [7:0] ADDR_MCTL = 8'h10;
	localparam logic [7:0] ADDR_LSTAT = 8'h14;
	localparam logic [7:0] ADDR_MSTAT = 8'h18;
	localparam logic [7:0] ADDR_SCRATCH = 8'h1C;
	localparam logic [7:0] ADDR_XFEAT = 8'h20;
	localparam logic [7:0] ADDR_INFRARED_PULSE_WIDTH = 8'h24;
	localparam logic [7:0] ADDR_ENH = 8'h28;
	localparam logic [7:0] ADDR_RXIN = 8'h2C;
	localparam logic [7:0] ADDR_IRQ = 8'h30;
	localparam int XF_HALF_DUPLEX = 0;
	localparam int XF_IR_INVERT = 1;
	localparam int XF_AUTO_485 = 2;
	localparam int XF_BAD_NOW = 3;
	localparam int XF_XON_ANY = 4;
	localparam int XF_485_INV = 5;
	localparam int MC_DTR = 0;
	localparam int MC_RTS = 1;
	localparam int MC_OUT1 = 2;
	localparam int MC_OUT2 = 3;
	localparam int MC_LOOP = 4;
	localparam int MC_IR_EN = 6;
	localparam int MC_PRESCALE = 7;
	localparam int LF_DIV_ACCESS = 7;
	localparam int IM_LINE = 2;
	localparam int IM_MODEM = 3;
	localparam int EN_AUTO_CTS = 7;
	localparam int PE_BIT = 8;
	localparam int FE_BIT = 9;
	localparam int BI_BIT = 10;
	localparam logic [7:0] SCRATCH_RST = 8'hFF;
	localparam logic [7:0] INFRARED_PULSE_WIDTH_RST = 8'h00;
	localparam logic [7:0] DIV_RST = 8'h01;
	localparam logic [3:0] PRESCALE_DIV = 4'h4;
	localparam logic [4:0] OVERSAMPLE = 5'h10;
	localparam logic [4:0] IR_DEF_TICKS = 5'h03;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// file: ufm_core.sv
// Register access over AXI4-Lite and the placing of the registers are this design's own decisions.
module ufm_core #(
	parameter int FIFO_DEPTH = 32
) (
	// Clock and reset
	input wire logic core_clk_in,
	input wire logic rst_n_in,
	// AXI4-Lite write
	input wire logic [7:0] s_axi_awaddr_in,
	input wire logic s_axi_awvalid_in,
	output logic s_axi_awready_out,
	input wire logic [31:0] s_axi_wdata_in,
	input wire logic [3:0] s_axi_wstrb_in,
	input wire logic s_axi_wvalid_in,
	output logic s_axi_wready_out,
	output logic [1:0] s_axi_bresp_out,
	output logic s_axi_bvalid_out,
	input wire logic s_axi_bready_in,
	// AXI4-Lite read
	input wire logic [7:0] s_axi_araddr_in,
	input wire logic s_axi_arvalid_in,
	output logic s_axi_arready_out,
	output logic [31:0] s_axi_rdata_out,
	output logic [1:0] s_axi_rresp_out,
	output logic s_axi_rvalid_out,
	input wire logic s_axi_rready_in,
	// Receive side events
	input wire logic rx_push_in,
	input wire logic [10:0] rx_word_in,
	input wire logic software_flow_in,
	// Transmit side status
	input wire logic tx_busy_in,
	input wire logic tx_char_done_in,
	// Modem pins, active low; infrared force pin, active high
	input wire logic clear_to_send_n_in,
	input wire logic data_set_ready_n_in,
	input wire logic ring_indicator_n_in,
	input wire logic carrier_detect_n_in,
	input wire logic infrared_force_pin_in,
	// Serial pins
	input wire logic serial_rx_in,
	input wire logic infrared_rx_in,
	input wire logic tx_bit_in,
	output logic serial_tx_out,
	output logic infrared_tx_out,
	output logic request_to_send_n_out,
	output logic terminal_ready_n_out,
	output logic out1_n_out,
	output logic out2_n_out,
	// Internal outputs
	output logic rx_bit_out,
	output logic baud16_tick_out,
	output logic tx_allow_out,
	output logic xon_resume_out,
	output logic line_irq_out,
	output logic modem_irq_out
);
	localparam int PW = $clog2(FIFO_DEPTH);
	if (FIFO_DEPTH < 2 || FIFO_DEPTH > 256 || (FIFO_DEPTH & (FIFO_DEPTH - 1)) != 0)
	begin
		$error("FIFO_DEPTH must be a power of two from 2 to 256");
	end

	// Register file
	logic [7:0] xfeat_r, mctl_r, lfmt_r, imask_r, enh_r, scratch_r, infrared_pulse_width_r;
	logic [7:0] div_lo_r, div_hi_r;
	logic ir_seed_r;
	// Receive FIFO
	logic [10:0] fifo_mem [FIFO_DEPTH];
	logic [PW-1:0] wp_r, rp_r;
	logic [PW:0] cnt_r, errcnt_r;
	// Bus
	logic aw_held_r, w_held_r;
	logic [7:0] aw_addr_r;
	logic [31:0] w_data_r;
	logic [3:0] w_strb_r;
	logic bvalid_r, rvalid_r;
	logic [1:0] bresp_r, rresp_r;
	logic [31:0] rdata_r;
	// Modem sync and status
	logic [3:0] ms_s1_r, ms_s2_r, ms_s3_r;
	logic [3:0] delta_r;
	logic [3:0] lvl_prev_r;
	logic prev_valid_r;
	logic line_irq_r;
	logic bad_head_seen_r;
	// Baud
	logic [1:0] pre_cnt_r;
	logic [15:0] div_cnt_r;
	logic tx_stop_r;
	logic [8:0] ir_cnt_r;
	logic ir_prev_tx_r;
	logic [2:0] irx_s_r;
	logic ir_lvl_r;

	// Bus decode
	wire do_write = aw_held_r && w_held_r && !bvalid_r;
	wire do_read = s_axi_arvalid_in && !rvalid_r;
	wire div_mode = lfmt_r[ufm_pkg::LF_DIV_ACCESS];
	wire [7:0] wb = w_data_r[7:0];
	wire wr_lane = w_strb_r[0];
	wire wr_div_lo = do_write && wr_lane && div_mode && aw_addr_r == ufm_pkg::ADDR_DATA;
	wire wr_div_hi = do_write && wr_lane && div_mode && aw_addr_r == ufm_pkg::ADDR_DIV_HIGH;
	wire wr_hit = aw_addr_r inside {ufm_pkg::ADDR_DATA, ufm_pkg::ADDR_DIV_HIGH, ufm_pkg::ADDR_IMASK,
		ufm_pkg::ADDR_LFMT, ufm_pkg::ADDR_MCTL, ufm_pkg::ADDR_SCRATCH, ufm_pkg::ADDR_XFEAT,
		ufm_pkg::ADDR_INFRARED_PULSE_WIDTH, ufm_pkg::ADDR_ENH};
	wire rd_lstat = do_read && s_axi_araddr_in == ufm_pkg::ADDR_LSTAT;
	wire rd_mstat = do_read && s_axi_araddr_in == ufm_pkg::ADDR_MSTAT;
	wire rd_pop = do_read && !div_mode && s_axi_araddr_in == ufm_pkg::ADDR_DATA && cnt_r != '0;

	// FIFO
	wire push = rx_push_in && cnt_r != (PW+1)'(FIFO_DEPTH);
	wire [10:0] head = fifo_mem[rp_r];
	wire head_bad = cnt_r != '0 && (head[ufm_pkg::PE_BIT] || head[ufm_pkg::FE_BIT]
		|| head[ufm_pkg::BI_BIT]);
	wire push_bad = push && (rx_word_in[ufm_pkg::PE_BIT] || rx_word_in[ufm_pkg::FE_BIT]
		|| rx_word_in[ufm_pkg::BI_BIT]);
	wire pop_bad = rd_pop && head_bad;
	wire fifo_err = errcnt_r != '0;
	wire [7:0] lstat = {fifo_err, ~tx_busy_in, cnt_r == '0, head_bad ? head[10:8] : 3'h0,
		1'b0, cnt_r != '0};

	// Modem status
	wire [3:0] pin_lvl = ~{carrier_detect_n_in, ring_indicator_n_in, data_set_ready_n_in,
		clear_to_send_n_in};
	wire [3:0] stable = ms_s2_r & ms_s3_r | (ms_s2_r | ms_s3_r) & lvl_prev_r;
	wire loop = mctl_r[ufm_pkg::MC_LOOP];
	wire [3:0] lvl = loop ? {mctl_r[ufm_pkg::MC_OUT2], mctl_r[ufm_pkg::MC_OUT1],
		mctl_r[ufm_pkg::MC_DTR], mctl_r[ufm_pkg::MC_RTS]} : stable;
	wire [3:0] chg = prev_valid_r ? (lvl ^ lvl_prev_r) : 4'h0;
	// Ring end: active level falls, pin rises
	wire [3:0] dset = {chg[3], chg[2] & lvl_prev_r[2], chg[1:0]};
	wire [3:0] delta_nxt = (rd_mstat ? 4'h0 : delta_r) | dset;
	wire [7:0] mstat = {lvl, delta_r};

	// Baud generation
	wire [15:0] divisor = {div_hi_r, div_lo_r};
	wire pre_tick = mctl_r[ufm_pkg::MC_PRESCALE] ? pre_cnt_r == 2'(ufm_pkg::PRESCALE_DIV - 1)
		: 1'b1;
	wire baud16 = pre_tick && div_cnt_r <= 16'h0001;

	// Infrared encode and decode
	wire ir_en = mctl_r[ufm_pkg::MC_IR_EN];
	wire ir_start = tx_bit_in == 1'b0 && ir_prev_tx_r && ir_en;
	wire [8:0] ir_len = infrared_pulse_width_r == 8'h00 ? 9'(ufm_pkg::IR_DEF_TICKS) : {1'b0, infrared_pulse_width_r};
	wire ir_pulse = ir_cnt_r != '0;
	wire ir_level = infrared_rx_in ^ xfeat_r[ufm_pkg::XF_IR_INVERT];
	wire ir_blank = xfeat_r[ufm_pkg::XF_HALF_DUPLEX] && tx_busy_in;
	wire ir_rx_bit = ir_blank ? 1'b1 : ~ir_lvl_r;
	wire auto485 = xfeat_r[ufm_pkg::XF_AUTO_485];
	wire dir_lvl = tx_busy_in ^ xfeat_r[ufm_pkg::XF_485_INV];
	wire bad_now = xfeat_r[ufm_pkg::XF_BAD_NOW];
	wire head_new_bad = head_bad && !bad_head_seen_r;
	wire line_set = imask_r[ufm_pkg::IM_LINE] && (bad_now ? (push_bad || head_new_bad)
		: head_new_bad);

	always_ff @(posedge core_clk_in)
	begin
		if (!rst_n_in)
		begin
			xfeat_r <= 8'h00;
			mctl_r <= 8'h00;
			lfmt_r <= 8'h00;
			imask_r <= 8'h00;
			enh_r <= 8'h00;
			infrared_pulse_width_r <= ufm_pkg::INFRARED_PULSE_WIDTH_RST;
			scratch_r <= ufm_pkg::SCRATCH_RST;
			div_lo_r <= ufm_pkg::DIV_RST;
			div_hi_r <= 8'h00;
			ir_seed_r <= 1'b1;
		end
		else
		begin
			ir_seed_r <= 1'b0;
			if (ir_seed_r)
				mctl_r[ufm_pkg::MC_IR_EN] <= infrared_force_pin_in;
			if (do_write && wr_lane)
			begin
				case (aw_addr_r)
					ufm_pkg::ADDR_DIV_HIGH: imask_r <= div_mode ? imask_r : wb;
					ufm_pkg::ADDR_IMASK: imask_r <= wb;
					ufm_pkg::ADDR_LFMT: lfmt_r <= wb;
					ufm_pkg::ADDR_MCTL: mctl_r <= wb;
					ufm_pkg::ADDR_SCRATCH: scratch_r <= wb;
					ufm_pkg::ADDR_XFEAT: xfeat_r <= {2'h0, wb[5:0]};
					ufm_pkg::ADDR_INFRARED_PULSE_WIDTH: infrared_pulse_width_r <= wb;
					ufm_pkg::ADDR_ENH: enh_r <= wb;
					default: ;
				endcase
			end
			if (wr_div_lo)
				div_lo_r <= wb;
			if (wr_div_hi)
				div_hi_r <= wb;
		end
	end

	always_ff @(posedge core_clk_in)
	begin
		if (push)
			fifo_mem[wp_r] <= rx_word_in;
	end

	always_ff @(posedge core_clk_in)
	begin
		if (!rst_n_in)
		begin
			wp_r <= '0;
			rp_r <= '0;
			cnt_r <= '0;
			errcnt_r <= '0;
			bad_head_seen_r <= 1'b0;
			line_irq_r <= 1'b0;
		end
		else
		begin
			if (push)
				wp_r <= wp_r + 1'b1;
			if (rd_pop)
				rp_r <= rp_r + 1'b1;
			cnt_r <= cnt_r + (PW+1)'(push) - (PW+1)'(rd_pop);
			errcnt_r <= errcnt_r + (PW+1)'(push_bad) - (PW+1)'(pop_bad);
			bad_head_seen_r <= rd_pop ? 1'b0 : head_bad;
			// New event wins over the clearing read
			line_irq_r <= line_set || (line_irq_r && !rd_lstat);
		end
	end

	always_ff @(posedge core_clk_in)
	begin
		if (!rst_n_in)
		begin
			ms_s1_r <= 4'h0;
			ms_s2_r <= 4'h0;
			ms_s3_r <= 4'h0;
			lvl_prev_r <= 4'h0;
			prev_valid_r <= 1'b0;
			delta_r <= 4'h0;
			irx_s_r <= 3'h0;
			ir_lvl_r <= 1'b0;
		end
		else
		begin
			ms_s1_r <= pin_lvl;
			ms_s2_r <= ms_s1_r;
			ms_s3_r <= ms_s2_r;
			lvl_prev_r <= lvl;
			prev_valid_r <= 1'b1;
			delta_r <= delta_nxt;
			irx_s_r <= {irx_s_r[1:0], ir_level};
			// Level moves only once second and third stage agree
			if (irx_s_r[1] == irx_s_r[2])
				ir_lvl_r <= irx_s_r[2];
		end
	end

	always_ff @(posedge core_clk_in)
	begin
		if (!rst_n_in)
		begin
			pre_cnt_r <= 2'h0;
			div_cnt_r <= 16'h0000;
			tx_stop_r <= 1'b0;
			ir_cnt_r <= 9'h000;
			ir_prev_tx_r <= 1'b1;
		end
		else
		begin
			pre_cnt_r <= pre_tick ? 2'h0 : pre_cnt_r + 2'h1;
			if (pre_tick)
				div_cnt_r <= baud16 ? divisor : div_cnt_r - 16'h0001;
			// Stop only at a character boundary
			if (!enh_r[ufm_pkg::EN_AUTO_CTS] || lvl[0])
				tx_stop_r <= 1'b0;
			else if (tx_char_done_in || !tx_busy_in)
				tx_stop_r <= 1'b1;
			ir_prev_tx_r <= tx_bit_in;
			// Default width counts 16x ticks, programmed width counts clocks
			if (ir_start)
				ir_cnt_r <= ir_len;
			else if (ir_cnt_r != '0 && (infrared_pulse_width_r != 8'h00 || baud16))
				ir_cnt_r <= ir_cnt_r - 9'h001;
		end
	end

	always_ff @(posedge core_clk_in)
	begin
		if (!rst_n_in)
		begin
			aw_held_r <= 1'b0;
			w_held_r <= 1'b0;
			aw_addr_r <= 8'h00;
			w_data_r <= 32'h0000_0000;
			w_strb_r <= 4'h0;
			bvalid_r <= 1'b0;
			bresp_r <= ufm_pkg::RESP_OKAY;
			rvalid_r <= 1'b0;
			rresp_r <= ufm_pkg::RESP_OKAY;
			rdata_r <= 32'h0000_0000;
		end
		else
		begin
			if (s_axi_awvalid_in && s_axi_awready_out)
			begin
				aw_held_r <= 1'b1;
				aw_addr_r <= {s_axi_awaddr_in[7:2], 2'h0};
			end
			if (s_axi_wvalid_in && s_axi_wready_out)
			begin
				w_held_r <= 1'b1;
				w_data_r <= s_axi_wdata_in;
				w_strb_r <= s_axi_wstrb_in;
			end
			if (do_write)
			begin
				aw_held_r <= 1'b0;
				w_held_r <= 1'b0;
				bvalid_r <= 1'b1;
				bresp_r <= wr_hit ? ufm_pkg::RESP_OKAY : ufm_pkg::RESP_SLVERR;
			end
			else if (bvalid_r && s_axi_bready_in)
				bvalid_r <= 1'b0;
			if (do_read)
			begin
				rvalid_r <= 1'b1;
				rresp_r <= ufm_pkg::RESP_OKAY;
				case ({s_axi_araddr_in[7:2], 2'h0})
					ufm_pkg::ADDR_DATA: rdata_r <= {24'h0, div_mode ? div_lo_r : head[7:0]};
					ufm_pkg::ADDR_DIV_HIGH: rdata_r <= {24'h0, div_mode ? div_hi_r : imask_r};
					ufm_pkg::ADDR_IMASK: rdata_r <= {24'h0, imask_r};
					ufm_pkg::ADDR_LFMT: rdata_r <= {24'h0, lfmt_r};
					ufm_pkg::ADDR_MCTL: rdata_r <= {24'h0, mctl_r};
					ufm_pkg::ADDR_LSTAT: rdata_r <= {24'h0, lstat};
					ufm_pkg::ADDR_MSTAT: rdata_r <= {24'h0, mstat};
					ufm_pkg::ADDR_SCRATCH: rdata_r <= {24'h0, scratch_r};
					ufm_pkg::ADDR_ENH: rdata_r <= {24'h0, enh_r};
					ufm_pkg::ADDR_RXIN: rdata_r <= {24'h0, 7'h0, rx_bit_out};
					ufm_pkg::ADDR_IRQ: rdata_r <= {30'h0, modem_irq_out, line_irq_r};
					ufm_pkg::ADDR_XFEAT, ufm_pkg::ADDR_INFRARED_PULSE_WIDTH: rdata_r <= 32'h0000_0000;
					default:
					begin
						rdata_r <= 32'h0000_0000;
						rresp_r <= ufm_pkg::RESP_SLVERR;
					end
				endcase
			end
			else if (rvalid_r && s_axi_rready_in)
				rvalid_r <= 1'b0;
		end
	end

	// Bus handshakes
	assign s_axi_awready_out = !aw_held_r;
	assign s_axi_wready_out = !w_held_r;
	assign s_axi_bvalid_out = bvalid_r;
	assign s_axi_bresp_out = bresp_r;
	assign s_axi_arready_out = !rvalid_r;
	assign s_axi_rvalid_out = rvalid_r;
	assign s_axi_rresp_out = rresp_r;
	assign s_axi_rdata_out = rdata_r;

	// Serial and modem pins
	assign serial_tx_out = loop || ir_en ? 1'b1 : tx_bit_in;
	assign infrared_tx_out = ir_en && !loop && ir_pulse;
	assign rx_bit_out = loop ? tx_bit_in : (ir_en ? ir_rx_bit : serial_rx_in);
	assign request_to_send_n_out = loop ? 1'b1 : (auto485 ? dir_lvl
		: ~mctl_r[ufm_pkg::MC_RTS]);
	assign terminal_ready_n_out = loop | ~mctl_r[ufm_pkg::MC_DTR];
	assign out1_n_out = loop | ~mctl_r[ufm_pkg::MC_OUT1];
	assign out2_n_out = loop | ~mctl_r[ufm_pkg::MC_OUT2];
	assign baud16_tick_out = baud16;
	assign tx_allow_out = !tx_stop_r;
	assign xon_resume_out = software_flow_in && xfeat_r[ufm_pkg::XF_XON_ANY] && push;
	assign line_irq_out = line_irq_r;
	assign modem_irq_out = imask_r[ufm_pkg::IM_MODEM] && delta_r != 4'h0;
endmodule

// file: ufm_core_asserts.sv
module ufm_core_asserts (
	// Clock and reset
	input wire logic core_clk_in,
	input wire logic rst_n_in,
	// Bus
	input wire logic [7:0] s_axi_awaddr_in,
	input wire logic s_axi_awvalid_in,
	input wire logic s_axi_awready_out,
	input wire logic [31:0] s_axi_wdata_in,
	input wire logic [1:0] s_axi_bresp_out,
	input wire logic s_axi_bvalid_out,
	input wire logic s_axi_bready_in,
	input wire logic s_axi_arvalid_in,
	input wire logic s_axi_arready_out,
	input wire logic [31:0] s_axi_rdata_out,
	input wire logic s_axi_rvalid_out,
	input wire logic s_axi_rready_in,
	// Pins and events
	input wire logic rx_push_in,
	input wire logic software_flow_in,
	input wire logic tx_busy_in,
	input wire logic serial_rx_in,
	input wire logic serial_tx_out,
	input wire logic infrared_tx_out,
	input wire logic request_to_send_n_out,
	input wire logic rx_bit_out,
	input wire logic xon_resume_out,
	input wire logic modem_irq_out
);
	timeunit 1ns;
	timeprecision 1ps;
	// Shadow of written bytes, settled once the response is taken
	logic [7:0] sh_r [16];
	logic [3:0] a_r;
	logic [7:0] d_r;
	logic pend_r;
	logic [8:0] hi_r;
	wire ok = !pend_r;
	wire [7:0] mc = sh_r[4];
	wire [7:0] xf = sh_r[8];
	always_ff @(posedge core_clk_in)
	begin
		if (!rst_n_in)
		begin
			sh_r <= '{default: 8'h00};
			pend_r <= 1'b0;
		end
		else if (s_axi_awvalid_in && s_axi_awready_out)
		begin
			a_r <= s_axi_awaddr_in[5:2];
			d_r <= s_axi_wdata_in[7:0];
			pend_r <= 1'b1;
		end
		else if (s_axi_bvalid_out && s_axi_bready_in)
		begin
			sh_r[a_r] <= d_r;
			pend_r <= 1'b0;
		end
	end
	// Length of the current infrared pulse
	always_ff @(posedge core_clk_in)
		hi_r <= infrared_tx_out ? hi_r + 9'h001 : 9'h000;
	default clocking @(posedge core_clk_in);
	endclocking
	default disable iff (!rst_n_in);
	a_rts_dir: assert property (ok && xf[2] && !mc[4] |->
		request_to_send_n_out == (tx_busy_in ^ xf[5])) else $error("rts direction wrong");
	a_rts_plain: assert property (ok && !xf[2] && !mc[4] |->
		request_to_send_n_out == !mc[1]) else $error("rts level wrong");
	a_ir_route: assert property (ok && (mc[6] || mc[4]) |->
		serial_tx_out) else $error("serial out not parked");
	a_ir_width: assert property (ok && mc[6] && sh_r[9] != 8'h00 &&
		$fell(infrared_tx_out) |-> hi_r == {1'b0, sh_r[9]}) else $error("ir width wrong");
	a_rx_path: assert property (ok && !mc[4] && !mc[6] |->
		rx_bit_out == serial_rx_in) else $error("rx path wrong");
	a_xon_any: assert property (ok && xf[4] && software_flow_in && rx_push_in |->
		xon_resume_out) else $error("xon any missing");
	a_msirq_mask: assert property (ok && modem_irq_out |-> sh_r[2][3])
		else $error("modem irq while masked");
	a_rd_answer: assert property (s_axi_arvalid_in && s_axi_arready_out |=> s_axi_rvalid_out)
		else $error("read answer late");
	a_b_hold: assert property (s_axi_bvalid_out && !s_axi_bready_in |=>
		s_axi_bvalid_out && $stable(s_axi_bresp_out)) else $error("write answer dropped");
	a_r_hold: assert property (s_axi_rvalid_out && !s_axi_rready_in |=>
		s_axi_rvalid_out && $stable(s_axi_rdata_out)) else $error("read answer dropped");
	cover property (ok && xf[2] && tx_busy_in);
	cover property (mc[6] && $fell(infrared_tx_out));
	cover property (modem_irq_out);
endmodule
bind ufm_core ufm_core_asserts u_chk (.*);

// file: ufm_modem.sv
module ufm_modem (
	// Requests from the bench
	input wire logic clk_in,
	input wire logic slow_in,
	input wire logic [3:0] want_n_in,
	input wire logic ir_on_in,
	input wire logic ir_inv_in,
	// Pins towards the block
	output logic [3:0] pin_n_out,
	output logic ir_out
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [3:0] d_r;
	// Pins follow in one or two cycles
	always_ff @(posedge clk_in)
	begin
		d_r <= want_n_in;
		pin_n_out <= slow_in ? d_r : want_n_in;
	end
	// Module idles at its own polarity
	assign ir_out = ir_on_in ^ ir_inv_in;
endmodule

// file: tb.sv
module tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic core_clk_in = 1'b0;
	logic rst_n_in = 1'b0;
	logic [7:0] awaddr = 8'h00, araddr = 8'h00;
	logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
	logic [31:0] wdata = 32'h0;
	logic push = 1'b0, sflow = 1'b0, busy = 1'b0, done = 1'b0, txb = 1'b1, srx = 1'b1;
	logic [10:0] word = 11'h000;
	logic [3:0] want_n = 4'hF;
	logic slow = 1'b0, ir_on = 1'b0, ir_inv = 1'b0;
	logic lag = 1'b0;
	logic [3:0] pin_n;
	logic ir, awready, wready, bvalid, arready, rvalid, stx, itx, rts_n, dtr_n, o1_n, o2_n;
	logic rxb, tick, allow, xon, lirq, mirq;
	logic [1:0] bresp, rresp, r;
	logic [31:0] rdata, d;
	int mismatches = 0, n_tests = 0;
	always #5 core_clk_in = ~core_clk_in;
	ufm_core uut (
		.core_clk_in(core_clk_in), .rst_n_in(rst_n_in),
		.s_axi_awaddr_in(awaddr), .s_axi_awvalid_in(awvalid), .s_axi_awready_out(awready),
		.s_axi_wdata_in(wdata), .s_axi_wstrb_in(4'h1), .s_axi_wvalid_in(wvalid),
		.s_axi_wready_out(wready), .s_axi_bresp_out(bresp), .s_axi_bvalid_out(bvalid),
		.s_axi_bready_in(bready), .s_axi_araddr_in(araddr), .s_axi_arvalid_in(arvalid),
		.s_axi_arready_out(arready), .s_axi_rdata_out(rdata), .s_axi_rresp_out(rresp),
		.s_axi_rvalid_out(rvalid), .s_axi_rready_in(rready), .rx_push_in(push),
		.rx_word_in(word), .software_flow_in(sflow), .tx_busy_in(busy), .tx_char_done_in(done),
		.clear_to_send_n_in(pin_n[0]), .data_set_ready_n_in(pin_n[1]),
		.ring_indicator_n_in(pin_n[2]), .carrier_detect_n_in(pin_n[3]),
		.infrared_force_pin_in(1'b0), .serial_rx_in(srx), .infrared_rx_in(ir),
		.tx_bit_in(txb), .serial_tx_out(stx), .infrared_tx_out(itx),
		.request_to_send_n_out(rts_n), .terminal_ready_n_out(dtr_n), .out1_n_out(o1_n),
		.out2_n_out(o2_n), .rx_bit_out(rxb), .baud16_tick_out(tick), .tx_allow_out(allow),
		.xon_resume_out(xon), .line_irq_out(lirq), .modem_irq_out(mirq)
	);
	ufm_modem modem (.clk_in(core_clk_in), .slow_in(slow), .want_n_in(want_n),
		.ir_on_in(ir_on), .ir_inv_in(ir_inv), .pin_n_out(pin_n), .ir_out(ir));
	task automatic chk_val(input logic [31:0] got, input logic [31:0] exp);
		n_tests++;
		if (got !== exp)
		begin
			mismatches++;
			$display("mismatch at %0t: got %h want %h", $time, got, exp);
		end
	endtask
	task automatic chk_bit(input logic got, input logic exp);
		chk_val({31'h0, got}, {31'h0, exp});
	endtask
	task automatic cyc(input int n);
		repeat (n) @(posedge core_clk_in);
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] v);
		awaddr <= a;
		wdata <= {24'h0, v};
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= !lag;
		do
		begin
			@(posedge core_clk_in);
			if (awready) awvalid <= 1'b0;
			if (wready) wvalid <= 1'b0;
			if (bvalid === 1'b1 && bready !== 1'b1) bready <= 1'b1;
		end while (!(bvalid === 1'b1 && bready === 1'b1));
		bready <= 1'b0;
		cyc(1);
	endtask
	task automatic rd(input logic [7:0] a);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= !lag;
		do
		begin
			@(posedge core_clk_in);
			if (arready) arvalid <= 1'b0;
			if (rvalid === 1'b1 && rready !== 1'b1) rready <= 1'b1;
		end while (!(rvalid === 1'b1 && rready === 1'b1));
		d = rdata;
		r = rresp;
		rready <= 1'b0;
		cyc(1);
	endtask
	task automatic rdc(input logic [7:0] a, input logic [7:0] m, input logic [7:0] e);
		rd(a);
		chk_val({24'h0, d[7:0] & m}, {24'h0, e});
	endtask
	task automatic ticks(input int span, input int exp);
		int n;
		n = 0;
		repeat (2)
			do @(posedge core_clk_in); while (tick !== 1'b1);
		repeat (span)
		begin
			@(posedge core_clk_in);
			n += int'(tick);
		end
		chk_val(32'(n), 32'(exp));
	endtask
	task automatic t_regs;
		rdc(8'h1C, 8'hFF, ufm_pkg::SCRATCH_RST);
		lag = 1'b1;
		wr(8'h1C, 8'h5A);
		rdc(8'h1C, 8'hFF, 8'h5A);
		lag = 1'b0;
		rdc(8'h20, 8'hFF, 8'h00);
		rd(8'h3C);
		chk_val({30'h0, r}, {30'h0, ufm_pkg::RESP_SLVERR});
		wr(8'h0C, 8'h80);
		rdc(8'h00, 8'hFF, 8'h01);
		wr(8'h04, 8'h01);
		wr(8'h00, 8'h00);
		rdc(8'h04, 8'hFF, 8'h01);
		ticks(512, 2);
		wr(8'h00, 8'h03);
		wr(8'h04, 8'h00);
		ticks(96, 32);
		wr(8'h10, 8'h80);
		ticks(96, 8);
		wr(8'h00, 8'h01);
		wr(8'h0C, 8'h00);
		rdc(8'h04, 8'hFF, 8'h00);
		wr(8'h10, 8'h00);
		$display("registers and divisor done");
	endtask
	task automatic t_modem;
		wr(8'h08, 8'h08);
		rd(8'h18);
		want_n <= 4'b1110;
		cyc(8);
		chk_bit(mirq, 1'b1);
		rdc(8'h18, 8'hFF, 8'h11);
		rdc(8'h18, 8'hFF, 8'h10);
		chk_bit(mirq, 1'b0);
		slow <= 1'b1;
		want_n <= 4'b1010;
		cyc(8);
		rdc(8'h18, 8'hFF, 8'h50);
		want_n <= 4'b1110;
		cyc(8);
		rdc(8'h18, 8'hFF, 8'h14);
		wr(8'h10, 8'h1F);
		rd(8'h18);
		chk_val({28'h0, rts_n, dtr_n, o1_n, o2_n}, 32'hF);
		rdc(8'h18, 8'hF0, 8'hF0);
		wr(8'h10, 8'h15);
		rdc(8'h18, 8'hF0, 8'h60);
		wr(8'h10, 8'h00);
		want_n <= 4'hF;
		cyc(8);
		rd(8'h18);
		wr(8'h08, 8'h00);
		$display("modem status done");
	endtask
	task automatic t_485;
		wr(8'h20, 8'h04);
		for (int i = 0; i < 4; i++)
		begin
			if (i == 2) wr(8'h10, 8'h02);
			if (i == 2) wr(8'h20, 8'h24);
			busy <= i[0];
			cyc(1);
			chk_bit(rts_n, i[0] ^ i[1]);
		end
		wr(8'h20, 8'h00);
		chk_bit(rts_n, 1'b0);
		wr(8'h10, 8'h00);
		busy <= 1'b0;
		$display("direction control done");
	endtask
	task automatic pulse(input int exp);
		int n;
		n = 0;
		for (int i = 0; i < 32; i++)
		begin
			txb <= (i >= 16);
			@(posedge core_clk_in);
			n += int'(itx);
		end
		chk_val(32'(n), 32'(exp));
	endtask
	task automatic rx_low(input logic exp);
		logic seen;
		seen = 1'b0;
		ir_on <= 1'b1;
		cyc(3);
		ir_on <= 1'b0;
		repeat (16)
		begin
			@(posedge core_clk_in);
			seen |= !rxb;
		end
		chk_bit(seen, exp);
		chk_bit(rxb, 1'b1);
	endtask
	task automatic t_ir;
		wr(8'h10, 8'h40);
		wr(8'h24, 8'h05);
		pulse(5);
		wr(8'h24, 8'h00);
		pulse(3);
		rx_low(1'b1);
		wr(8'h20, 8'h02);
		ir_inv <= 1'b1;
		cyc(8);
		rx_low(1'b1);
		ir_inv <= 1'b0;
		wr(8'h20, 8'h01);
		busy <= 1'b1;
		cyc(8);
		rx_low(1'b0);
		busy <= 1'b0;
		rx_low(1'b1);
		wr(8'h20, 8'h00);
		wr(8'h10, 8'h00);
		$display("infrared done");
	endtask
	task automatic put(input logic [10:0] w);
		push <= 1'b1;
		word <= w;
		cyc(1);
		push <= 1'b0;
		cyc(1);
	endtask
	task automatic t_lsr;
		wr(8'h08, 8'h04);
		put(11'h041);
		put(11'h142);
		cyc(4);
		chk_bit(lirq, 1'b0);
		rdc(8'h14, 8'h80, 8'h80);
		rdc(8'h00, 8'hFF, 8'h41);
		cyc(4);
		chk_bit(lirq, 1'b1);
		rdc(8'h14, 8'h84, 8'h84);
		rdc(8'h00, 8'hFF, 8'h42);
		rdc(8'h14, 8'h80, 8'h00);
		wr(8'h20, 8'h08);
		put(11'h041);
		put(11'h442);
		cyc(4);
		chk_bit(lirq, 1'b1);
		rd(8'h14);
		cyc(2);
		chk_bit(lirq, 1'b0);
		rd(8'h00);
		cyc(4);
		chk_bit(lirq, 1'b1);
		rd(8'h14);
		rd(8'h00);
		sflow <= 1'b1;
		wr(8'h20, 8'h10);
		push <= 1'b1;
		word <= 11'h055;
		@(negedge core_clk_in);
		chk_bit(xon, 1'b1);
		cyc(1);
		push <= 1'b0;
		rd(8'h00);
		sflow <= 1'b0;
		wr(8'h20, 8'h00);
		wr(8'h08, 8'h00);
		$display("line status done");
	endtask
	task automatic t_cts;
		wr(8'h28, 8'h80);
		busy <= 1'b1;
		want_n <= 4'b1110;
		cyc(8);
		chk_bit(allow, 1'b1);
		want_n <= 4'hF;
		cyc(8);
		chk_bit(allow, 1'b1);
		done <= 1'b1;
		cyc(1);
		done <= 1'b0;
		cyc(3);
		chk_bit(allow, 1'b0);
		want_n <= 4'b1110;
		cyc(8);
		chk_bit(allow, 1'b1);
		$display("clear to send done");
	endtask
	task automatic end_of_test;
		$display("compares %0d, mismatches %0d", n_tests, mismatches);
		if (mismatches == 0 && n_tests > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	initial
	begin
		#200us;
		mismatches++;
		end_of_test();
	end
	initial
	begin
		cyc(12);
		rst_n_in <= 1'b1;
		t_regs();
		t_modem();
		t_485();
		t_ir();
		t_lsr();
		t_cts();
		end_of_test();
	end
endmodule
